/* File: verilog/rtcc_pkg.sv */
// package: register map, field positions and counting constants of the clock block
package rtcc_pkg;

  localparam logic [7:0]  RTCC_CONFIG_ADDR   = 8'hA1;
  localparam logic [7:0]  RTCC_CENTI_ADDR    = 8'hA2;
  localparam logic [7:0]  RTCC_SEC_ADDR      = 8'hA3;
  localparam logic [7:0]  RTCC_MIN_ADDR      = 8'hA4;
  localparam logic [7:0]  RTCC_HOUR_ADDR     = 8'hA5;
  localparam logic [7:0]  RTCC_PERIOD_ADDR   = 8'hA6;
  localparam logic [7:0]  RTCC_KEY_ADDR      = 8'hC1;
  localparam logic [7:0]  RTCC_NTRIM_ADDR    = 8'hF6;
  localparam logic [7:0]  RTCC_TTRIM_ADDR    = 8'hF7;
  localparam logic [7:0]  RTCC_IRQPIN_ADDR   = 8'hFF;

  localparam logic [7:0]  RTCC_UNLOCK_VALUE  = 8'hEA;

  localparam int          RTCC_MIDNIGHT_BIT  = 7;
  localparam int          RTCC_DAYWRAP_BIT   = 6;
  localparam int          RTCC_BASE_HI_BIT   = 5;
  localparam int          RTCC_BASE_LO_BIT   = 4;
  localparam int          RTCC_ONESHOT_BIT   = 3;
  localparam int          RTCC_ALARM_BIT     = 2;
  localparam int          RTCC_ALARM_EN_BIT  = 1;

  localparam logic [7:0]  RTCC_ZERO8         = 8'h00;
  localparam logic [7:0]  RTCC_ONE8          = 8'h01;
  localparam logic [1:0]  RTCC_BASE_RESET    = 2'h0;
  localparam logic [7:0]  RTCC_CENTI_MAX     = 8'h63;
  localparam logic [7:0]  RTCC_SEC_MAX       = 8'h3B;
  localparam logic [7:0]  RTCC_MIN_MAX       = 8'h3B;
  localparam logic [7:0]  RTCC_HOUR24_MAX    = 8'h17;
  localparam logic [7:0]  RTCC_HOUR256_MAX   = 8'hFF;

  // crystal edges per second, and centi steps added per edge
  localparam logic [16:0] RTCC_XTAL_HZ       = 17'h0_8000;
  localparam logic [16:0] RTCC_CENTI_STEP    = 17'h0_0064;
  // 32768 / 128 edges per 1/128 s tick
  localparam logic [7:0]  RTCC_DIV128_MAX    = 8'hFF;

  typedef enum logic [1:0] {
    RTCC_BASE_128TH,
    RTCC_BASE_SECOND,
    RTCC_BASE_MINUTE,
    RTCC_BASE_HOUR
  } rtcc_base_t;

endpackage : rtcc_pkg

/* File: verilog/rtcc_tick_gen.sv */
// crystal synchroniser, trimmed hundredths tick and 1/128 s tick
`timescale 1ns/10ps
`default_nettype none
module rtcc_tick_gen
  import rtcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       xtal_in,
  input  wire logic [7:0] nominal_trim,
  input  wire logic [7:0] thermal_trim,
  output logic            centi_tick,
  output logic            base128_tick
);

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic [16:0] acc;
    logic [7:0]  div128;
    logic        centi;
    logic        b128;
  } rtcc_tick_state_t;

  rtcc_tick_state_t q;
  rtcc_tick_state_t d;
  logic             xtal_edge;
  logic [16:0]      modulus;
  logic [16:0]      acc_sum;

  assign xtal_edge = q.sync2 & ~q.prev;

  // each trim unit moves the per-second crystal-count modulus by one count, the hundredth by 1/100 count
  assign modulus = RTCC_XTAL_HZ - {{9{nominal_trim[7]}}, nominal_trim} - {{9{thermal_trim[7]}}, thermal_trim};
  assign acc_sum = q.acc + RTCC_CENTI_STEP;

  always_comb begin
    d       = q;
    // only the second stage reads the first
    d.sync1 = xtal_in;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.centi = 1'b0;
    d.b128  = 1'b0;
    if (xtal_edge) begin
      if (acc_sum >= modulus) begin
        d.acc   = acc_sum - modulus;
        d.centi = 1'b1;
      end else begin
        d.acc = acc_sum;
      end
      d.div128 = q.div128 + RTCC_ONE8;
      if (q.div128 == RTCC_DIV128_MAX) begin
        d.b128 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign centi_tick   = q.centi;
  assign base128_tick = q.b128;

endmodule : rtcc_tick_gen
`default_nettype wire

/* File: verilog/rtcc_core.sv */
// real-time clock core: byte-wide special registers, time chain, midnight and alarm flags
//
// Contract
// - counters advance on crystal, not core clock
// - separate nominal and temperature trim settings
// - keeps counting in every power mode
// - counters survive watchdog and pin resets
// - registers accessed only as whole bytes
// - protected writes need key 0xEA loaded
// - midnight flag set on wrap to zero
// - midnight flag stays until software clears
// - 24-hour mode: one midnight per day
// - midnight wake blocks sleep until cleared
// - day wrap bit defaults 0, power-on only
// - wrap bit 0: hours wrap 255 to 0
// - wrap bit 1: hours wrap 23 to 0
// - bits 5..4 select alarm time base
// - periodic alarm: flag each interval, restart
// - one-shot alarm: flag on the first time-base tick, then disable
`timescale 1ns/10ps
`default_nettype none
module rtcc_core
  import rtcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       core_rst_n,
  input  wire logic       xtal_in,
  input  wire logic       sleep_mode,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  output logic            sfr_ack,
  output logic [7:0]      irq_pin_config,
  output logic            midnight_flag,
  output logic            alarm_flag,
  output logic            sleep_entry_block
);

  typedef struct packed {
    logic [7:0] centi;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic       midnight;
    logic       day_wrap;
    rtcc_base_t base_sel;
    logic       one_shot;
    logic       alarm;
    logic       alarm_en;
    logic [7:0] period;
    logic [7:0] alarm_cnt;
    logic [7:0] key;
    logic [7:0] ntrim;
    logic [7:0] ttrim;
    logic [7:0] irq_pin;
    logic       midnight_wake;
    logic       sleep_block;
    logic [7:0] rdata;
    logic       ack;
  } rtcc_state_t;

  rtcc_state_t q;
  rtcc_state_t d;

  logic       centi_tick;
  logic       base128_tick;
  logic       sec_carry;
  logic       min_carry;
  logic       hour_carry;
  logic       day_carry;
  logic       base_tick;
  logic       unlocked;
  logic       wr_cfg;
  logic [7:0] hour_max;
  logic [7:0] alarm_limit;
  logic [7:0] cfg_view;
  logic [7:0] alarm_next;

  // byte-wide decode only; there is no per-bit access path
  function automatic logic rtcc_mapped(input logic [7:0] a);
    unique case (a)
      RTCC_CONFIG_ADDR, RTCC_CENTI_ADDR, RTCC_SEC_ADDR, RTCC_MIN_ADDR,
      RTCC_HOUR_ADDR, RTCC_PERIOD_ADDR, RTCC_KEY_ADDR, RTCC_NTRIM_ADDR,
      RTCC_TTRIM_ADDR, RTCC_IRQPIN_ADDR: rtcc_mapped = 1'b1;
      default: rtcc_mapped = 1'b0;
    endcase
  endfunction : rtcc_mapped

  function automatic logic rtcc_protected(input logic [7:0] a);
    unique case (a)
      RTCC_CENTI_ADDR, RTCC_SEC_ADDR, RTCC_MIN_ADDR,
      RTCC_HOUR_ADDR, RTCC_IRQPIN_ADDR: rtcc_protected = 1'b1;
      default: rtcc_protected = 1'b0;
    endcase
  endfunction : rtcc_protected

  // ticks derive from the synchronised crystal
  rtcc_tick_gen u_tick (
    .clk          (clk),
    .nrst         (nrst),
    .xtal_in      (xtal_in),
    .nominal_trim (q.ntrim),
    .thermal_trim (q.ttrim),
    .centi_tick   (centi_tick),
    .base128_tick (base128_tick)
  );

  assign hour_max   = q.day_wrap ? RTCC_HOUR24_MAX : RTCC_HOUR256_MAX;

  assign sec_carry  = centi_tick & (q.centi == RTCC_CENTI_MAX);
  assign min_carry  = sec_carry & (q.sec == RTCC_SEC_MAX);
  assign hour_carry = min_carry & (q.min == RTCC_MIN_MAX);
  assign day_carry  = hour_carry & (q.hour >= hour_max);

  assign unlocked   = (q.key == RTCC_UNLOCK_VALUE);
  assign wr_cfg     = sfr_wr & (sfr_addr == RTCC_CONFIG_ADDR);

  // time base for the interval timer
  always_comb begin
    unique case (q.base_sel)
      RTCC_BASE_128TH:  base_tick = base128_tick;
      RTCC_BASE_SECOND: base_tick = sec_carry;
      RTCC_BASE_MINUTE: base_tick = min_carry;
      RTCC_BASE_HOUR:   base_tick = hour_carry;
    endcase
  end

  assign alarm_limit = q.one_shot ? RTCC_ONE8 : q.period;
  assign alarm_next  = q.alarm_cnt + RTCC_ONE8;

  always_comb begin
    cfg_view                    = RTCC_ZERO8;
    cfg_view[RTCC_MIDNIGHT_BIT] = q.midnight;
    cfg_view[RTCC_DAYWRAP_BIT]  = q.day_wrap;
    cfg_view[RTCC_BASE_HI_BIT:RTCC_BASE_LO_BIT] = q.base_sel;
    cfg_view[RTCC_ONESHOT_BIT]  = q.one_shot;
    cfg_view[RTCC_ALARM_BIT]    = q.alarm;
    cfg_view[RTCC_ALARM_EN_BIT] = q.alarm_en;
  end

  always_comb begin
    d     = q;
    d.ack = 1'b0;

    // no power-mode input gates the chain
    if (centi_tick) begin
      d.centi = sec_carry ? RTCC_ZERO8 : q.centi + RTCC_ONE8;
    end
    // seconds and minutes wrap at 59
    if (sec_carry) begin
      d.sec = min_carry ? RTCC_ZERO8 : q.sec + RTCC_ONE8;
    end
    if (min_carry) begin
      d.min = hour_carry ? RTCC_ZERO8 : q.min + RTCC_ONE8;
    end
    if (hour_carry) begin
      d.hour = day_carry ? RTCC_ZERO8 : q.hour + RTCC_ONE8;
    end

    // protected writes only while the key holds the unlock value
    if (sfr_wr && unlocked && rtcc_protected(sfr_addr)) begin
      unique case (sfr_addr)
        RTCC_CENTI_ADDR:  d.centi   = sfr_wdata;
        RTCC_SEC_ADDR:    d.sec     = sfr_wdata;
        RTCC_MIN_ADDR:    d.min     = sfr_wdata;
        RTCC_HOUR_ADDR:   d.hour    = sfr_wdata;
        RTCC_IRQPIN_ADDR: d.irq_pin = sfr_wdata;
        default:          d.irq_pin = q.irq_pin;
      endcase
    end

    // key stays as written until software rewrites it or a core reset zeroes it
    if (sfr_wr) begin
      unique case (sfr_addr)
        RTCC_KEY_ADDR:    d.key    = sfr_wdata;
        RTCC_PERIOD_ADDR: d.period = sfr_wdata;
        RTCC_NTRIM_ADDR:  d.ntrim  = sfr_wdata;
        RTCC_TTRIM_ADDR:  d.ttrim  = sfr_wdata;
        default:          d.key    = q.key;
      endcase
    end

    if (wr_cfg) begin
      d.day_wrap = sfr_wdata[RTCC_DAYWRAP_BIT];
      d.base_sel = rtcc_base_t'(sfr_wdata[RTCC_BASE_HI_BIT:RTCC_BASE_LO_BIT]);
      d.one_shot = sfr_wdata[RTCC_ONESHOT_BIT];
      d.alarm_en = sfr_wdata[RTCC_ALARM_EN_BIT];
      // flags clear only on a written zero
      if (!sfr_wdata[RTCC_MIDNIGHT_BIT]) begin
        d.midnight = 1'b0;
      end
      if (!sfr_wdata[RTCC_ALARM_BIT]) begin
        d.alarm = 1'b0;
      end
      // restart the interval whenever the config register is written; a period write keeps the count
      d.alarm_cnt = RTCC_ZERO8;
    end else if (q.alarm_en && base_tick) begin
      if (alarm_next >= alarm_limit) begin
        d.alarm     = 1'b1;
        d.alarm_cnt = RTCC_ZERO8;
        if (q.one_shot) begin
          d.alarm_en = 1'b0;
        end
      end else begin
        d.alarm_cnt = alarm_next;
      end
    end

    // set on rollover, winning over a same-cycle clear
    // day_carry fires once per 24 hours in day mode
    if (day_carry) begin
      d.midnight = 1'b1;
      if (sleep_mode) begin
        d.midnight_wake = 1'b1;
      end
    end
    if (!d.midnight) begin
      d.midnight_wake = 1'b0;
    end
    // sleep refused while a midnight wake is unserviced
    d.sleep_block = d.midnight & d.midnight_wake;

    if (rtcc_mapped(sfr_addr) && (sfr_wr || sfr_rd)) begin
      d.ack = 1'b1;
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        RTCC_CONFIG_ADDR: d.rdata = cfg_view;
        RTCC_CENTI_ADDR:  d.rdata = q.centi;
        RTCC_SEC_ADDR:    d.rdata = q.sec;
        RTCC_MIN_ADDR:    d.rdata = q.min;
        RTCC_HOUR_ADDR:   d.rdata = q.hour;
        RTCC_PERIOD_ADDR: d.rdata = q.period;
        RTCC_KEY_ADDR:    d.rdata = q.key;
        RTCC_NTRIM_ADDR:  d.rdata = q.ntrim;
        RTCC_TTRIM_ADDR:  d.rdata = q.ttrim;
        RTCC_IRQPIN_ADDR: d.rdata = q.irq_pin;
        default:          d.rdata = RTCC_ZERO8;
      endcase
    end

    // warm resets leave the time chain, day wrap and midnight flag alone
    // day wrap kept through warm resets
    if (!core_rst_n) begin
      d.key       = RTCC_ZERO8;
      d.irq_pin   = RTCC_ZERO8;
      d.period    = RTCC_ZERO8;
      d.alarm_cnt = RTCC_ZERO8;
      d.base_sel  = rtcc_base_t'(RTCC_BASE_RESET);
      d.one_shot  = 1'b0;
      d.alarm     = 1'b0;
      d.alarm_en  = 1'b0;
      d.rdata     = RTCC_ZERO8;
      d.ack       = 1'b0;
    end
  end

  // only power-on reset clears the counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata         = q.rdata;
  assign sfr_ack           = q.ack;
  assign irq_pin_config    = q.irq_pin;
  assign midnight_flag     = q.midnight;
  assign alarm_flag        = q.alarm;
  assign sleep_entry_block = q.sleep_block;

endmodule : rtcc_core
`default_nettype wire

/* File: tb/rtcc_core_properties.sv */
// checker: bus, key and flag relations at the clock core ports
`timescale 1ns/10ps
`default_nettype none
module rtcc_core_checker
  import rtcc_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       core_rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_ack,
  input wire logic [7:0] irq_pin_config,
  input wire logic       midnight_flag,
  input wire logic       sleep_entry_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // key mirror, so a locked write can be told from an open one
  logic [7:0] key_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) key_q <= 8'h00;
    else if (!core_rst_n) key_q <= 8'h00;
    else if (sfr_wr && sfr_addr == RTCC_KEY_ADDR) key_q <= sfr_wdata;
  end
  sequence s_unlock;
    sfr_wr && sfr_addr == RTCC_KEY_ADDR && sfr_wdata == RTCC_UNLOCK_VALUE && core_rst_n;
  endsequence
  sequence s_pin_wr;
    sfr_wr && sfr_addr == RTCC_IRQPIN_ADDR && core_rst_n;
  endsequence
  property p_ack; core_rst_n && (sfr_wr || sfr_rd) && sfr_addr == RTCC_CONFIG_ADDR |=> sfr_ack; endproperty
  property p_no_ack; !(sfr_wr || sfr_rd) |=> !sfr_ack; endproperty
  property p_unmapped; sfr_rd && sfr_addr == 8'h10 |=> sfr_rdata == RTCC_ZERO8 && !sfr_ack; endproperty
  property p_rd_hold; core_rst_n && !sfr_rd |=> $stable(sfr_rdata); endproperty
  property p_mid_hold; midnight_flag && !(sfr_wr && sfr_addr == RTCC_CONFIG_ADDR) |=> midnight_flag; endproperty
  property p_irq_lock; s_pin_wr and key_q != RTCC_UNLOCK_VALUE |=> $stable(irq_pin_config); endproperty
  property p_irq_open; s_unlock ##2 s_pin_wr |=> irq_pin_config == $past(sfr_wdata); endproperty
  property p_block; sleep_entry_block |-> midnight_flag || $past(midnight_flag); endproperty
  property p_core_rst; !core_rst_n |=> irq_pin_config == RTCC_ZERO8 && !sfr_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after config access");
  a_no_ack: assert property (p_no_ack) else $error("ack without access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  a_mid_hold: assert property (p_mid_hold) else $error("midnight flag dropped by itself");
  a_irq_lock: assert property (p_irq_lock) else $error("locked pin config written");
  a_irq_open: assert property (p_irq_open) else $error("unlocked pin config not written");
  a_block: assert property (p_block) else $error("sleep block without midnight flag");
  a_core_rst: assert property (p_core_rst) else $error("core reset did not clear");
endmodule : rtcc_core_checker
bind rtcc_core rtcc_core_checker u_chk (.clk(clk), .nrst(nrst), .core_rst_n(core_rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_ack(sfr_ack),
  .irq_pin_config(irq_pin_config), .midnight_flag(midnight_flag), .sleep_entry_block(sleep_entry_block));
`default_nettype wire

/* File: tb/rtcc_core_tb.sv */
// testbench: register access, resets, rollover and alarm of the clock core
`timescale 1ns/10ps
`default_nettype none
module rtcc_core_tb
  import rtcc_pkg::*;
;
  logic       clk;
  logic       nrst;
  logic       core_rst_n;
  logic       sleep_mode;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] irq_pin_config;
  logic       sfr_ack;
  logic       midnight_flag;
  logic       alarm_flag;
  logic       sleep_entry_block;
  logic [2:0] xdiv = 3'h0;
  int         errors;
  int         checks;
  rtcc_core dut_u (.clk(clk), .nrst(nrst), .core_rst_n(core_rst_n), .xtal_in(xdiv[2]),
    .sleep_mode(sleep_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_ack(sfr_ack), .irq_pin_config(irq_pin_config),
    .midnight_flag(midnight_flag), .alarm_flag(alarm_flag), .sleep_entry_block(sleep_entry_block));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // crystal far faster than nominal keeps the run short
  always @(posedge clk) xdiv <= xdiv + 3'h1;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1 chk("ack", 8'h01, {7'h00, sfr_ack});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk($sformatf("reg_%h", a), exp, sfr_rdata);
  endtask : rd
  task automatic wait_flag(input bit sel, input int lim);
    int n;
    n = 0;
    while ((sel ? alarm_flag : midnight_flag) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1 chk("flag", 8'h01, {7'h00, sel ? alarm_flag : midnight_flag});
  endtask : wait_flag
  task automatic set_time(input logic [7:0] h);
    wr(RTCC_KEY_ADDR, RTCC_UNLOCK_VALUE);
    wr(RTCC_HOUR_ADDR, h);
    wr(RTCC_MIN_ADDR, 8'h3B);
    wr(RTCC_SEC_ADDR, 8'h3B);
    wr(RTCC_CENTI_ADDR, 8'h63);
    wr(RTCC_KEY_ADDR, 8'h00);
  endtask : set_time
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    core_rst_n = 1'b1;
    sleep_mode = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(RTCC_CONFIG_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    chk("unmapped_ack", 8'h00, {7'h00, sfr_ack});
    wr(RTCC_SEC_ADDR, 8'h10);
    wr(RTCC_IRQPIN_ADDR, 8'h80);
    rd(RTCC_SEC_ADDR, 8'h00);
    chk("irq_pin", 8'h00, irq_pin_config);
    wr(RTCC_NTRIM_ADDR, 8'h7F);
    wr(RTCC_TTRIM_ADDR, 8'h7F);
    rd(RTCC_NTRIM_ADDR, 8'h7F);
    rd(RTCC_TTRIM_ADDR, 8'h7F);
    wr(RTCC_KEY_ADDR, RTCC_UNLOCK_VALUE);
    wr(RTCC_IRQPIN_ADDR, 8'h80);
    chk("irq_pin", 8'h80, irq_pin_config);
    wr(RTCC_CONFIG_ADDR, 8'h40);
    wr(RTCC_HOUR_ADDR, 8'h17);
    @(posedge clk);
    core_rst_n <= 1'b0;
    @(posedge clk);
    core_rst_n <= 1'b1;
    rd(RTCC_HOUR_ADDR, 8'h17);
    rd(RTCC_CONFIG_ADDR, 8'h40);
    chk("irq_pin", 8'h00, irq_pin_config);
    sleep_mode <= 1'b1;
    set_time(8'h17);
    wait_flag(1'b0, 3200);
    rd(RTCC_HOUR_ADDR, 8'h00);
    rd(RTCC_MIN_ADDR, 8'h00);
    rd(RTCC_SEC_ADDR, 8'h00);
    chk("sleep_block", 8'h01, {7'h00, sleep_entry_block});
    sleep_mode <= 1'b0;
    rd(RTCC_CONFIG_ADDR, 8'hC0);
    wr(RTCC_CONFIG_ADDR, 8'h40);
    chk("midnight", 8'h00, {7'h00, midnight_flag});
    chk("sleep_block", 8'h00, {7'h00, sleep_entry_block});
    wr(RTCC_CONFIG_ADDR, 8'h00);
    set_time(8'hFF);
    wait_flag(1'b0, 3200);
    rd(RTCC_HOUR_ADDR, 8'h00);
    wr(RTCC_PERIOD_ADDR, 8'h02);
    wr(RTCC_CONFIG_ADDR, 8'h02);
    wait_flag(1'b1, 5000);
    wr(RTCC_CONFIG_ADDR, 8'h02);
    chk("alarm", 8'h00, {7'h00, alarm_flag});
    wait_flag(1'b1, 5000);
    wr(RTCC_CONFIG_ADDR, 8'h0A);
    wait_flag(1'b1, 5000);
    rd(RTCC_CONFIG_ADDR, 8'h0C);
    wr(RTCC_PERIOD_ADDR, 8'h01);
    // seconds base: one alarm on the next second carry
    wr(RTCC_CONFIG_ADDR, 8'h12);
    set_time(8'h07);
    wait_flag(1'b1, 3200);
    rd(RTCC_SEC_ADDR, 8'h00);
    // hour base: alarm lands with the hour carry
    wr(RTCC_CONFIG_ADDR, 8'h32);
    set_time(8'h05);
    wait_flag(1'b1, 3200);
    rd(RTCC_HOUR_ADDR, 8'h06);
    stop_test();
  end
endmodule : rtcc_core_tb
`default_nettype wire
